// *** hdl/mps_pkg.sv ***
/*
  Constants and types for the module power-state controller.
  Assumes a 10 MHz system clock and active-low asynchronous reset.
*/
package mps_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int MIN_PULSE_MS = 16;
  localparam int MIN_PULSE_CYC = (MIN_PULSE_MS * (CLK_HZ / 1000));
  localparam int SUSPEND_WARN_CYC = 16;
  localparam int RESET_HOLD_CYC = 32;
  // ----------------------------------------------------------------
  // Pinout straps: grounded = 0, open = 1 (bit2, bit1, bit0)
  // ----------------------------------------------------------------
  localparam logic [2:0] PINOUT_CODE_N = 3'h3;
  // ----------------------------------------------------------------
  // Power states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MPS_OFF = 3'h0,
    MPS_RUN = 3'h1,
    MPS_WARN = 3'h3,
    MPS_RAM = 3'h2,
    MPS_DISK = 3'h6
  } mps_state_type;
endpackage : mps_pkg

// *** hdl/mps_ctrl.sv ***
/*
  Power-state and reset controller of the module edge.
  Holds the sleep state machine, the carrier reset, the watchdog and
  thermal outputs, the wake and event logic and the pinout straps.
  Assumes one 10 MHz clock; all pin inputs are asynchronous to it.
*/
// Contract
// - Falling power button edge, held 16 ms, leaves soft-off.
// - Reset button is edge triggered; low level does not hold reset.
// - Carrier reset low on button, power bad, low supply, watchdog, software.
// - Supply-good high means main power valid.
// - Suspend-to-RAM output low only in suspend-to-RAM.
// - Suspend-to-disk low in disk state; soft-off asserted in soft-off.
// - Suspend-pending goes low before any suspend begins.
// - PCIe and general wake inputs wake the system from sleep.
// - Battery-low input event is registered.
// - Low over-temperature input is an over-temperature condition.
// - Thermal shutdown output low once the processor trips; the code releases it in soft-off and ignores trips there.
// - SMBus alert raises management interrupt or wakes the system.
// - Lid and sleep button events, held 16 ms, sleep or wake.
// - Watchdog output asserted after a watchdog time-out.
// - Three strap pins present type 6: top bit grounded.
`timescale 1ns/1ps
module mps_ctrl #(
  parameter int PULSE_CYC = mps_pkg::MIN_PULSE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic power_button_n,
  input wire logic reset_button_n,
  input wire logic supply_good,
  input wire logic main_supply_low,
  input wire logic pcie_wake_n,
  input wire logic gp_wake_n,
  input wire logic battery_low_n,
  input wire logic overtemp_in_n,
  input wire logic smbus_alert_n,
  input wire logic lid_n,
  input wire logic sleep_button,
  input wire logic cpu_thermal_trip,
  input wire logic watchdog_timeout,
  input wire logic sw_reset_req,
  input wire logic sw_sleep_ram,
  input wire logic sw_sleep_disk,
  input wire logic sw_soft_off,
  input wire logic smbus_alert_wake_en,
  input wire logic event_clear,
  output logic carrier_reset_out_n,
  output logic suspend_ram_n,
  output logic suspend_disk_n,
  output logic soft_off_n,
  output logic suspend_pending_n,
  output logic cpu_thermal_shutdown_n,
  output logic watchdog_expired,
  output logic mgmt_interrupt_n,
  output logic overtemp_event,
  output logic battery_low_event,
  output logic lid_event,
  output logic sleep_button_event,
  output logic [2:0] pinout_code_n
);
  // ----------------------------------------------------------------
  // Input synchronisers and pulse qualification
  // ----------------------------------------------------------------
  localparam int NIN = 9;
  localparam int CW = $clog2(PULSE_CYC + 1);
  logic [NIN-1:0] raw_act, sync1, act;
  logic [NIN-1:0] next_sync1, next_act;
  logic [CW-1:0] cnt [0:3];
  logic [CW-1:0] next_cnt [0:3];
  logic [3:0] qual, next_qual, qual_rise;
  // Supply levels cross the same two flops. Both reset to 0, so supply-good reads as power bad and carrier reset stays low until they settle.
  logic [1:0] pwr_sync1, pwr_act, next_pwr_sync1, next_pwr_act;
  // Active-high view: 0 pwr, 1 rst, 2 lid, 3 sleep, 4 pcie, 5 gp, 6 bat, 7 temp, 8 alert.
  assign raw_act = {~smbus_alert_n, ~overtemp_in_n, ~battery_low_n, ~gp_wake_n, ~pcie_wake_n,
                    sleep_button, ~lid_n, ~reset_button_n, ~power_button_n};
  always_comb begin
    next_sync1 = raw_act;
    next_act = sync1;
    next_pwr_sync1 = {main_supply_low, supply_good};
    next_pwr_act = pwr_sync1;
    for (int i = 0; i < 4; i++) begin
      next_cnt[i] = act[i] ? ((cnt[i] == CW'(PULSE_CYC)) ? cnt[i] : cnt[i] + 1'b1) : '0;
      next_qual[i] = act[i] && (cnt[i] == CW'(PULSE_CYC - 1) || qual[i]);
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= '0;
      act <= '0;
      pwr_sync1 <= '0;
      pwr_act <= '0;
      qual <= '0;
      for (int i = 0; i < 4; i++) cnt[i] <= '0;
    end else begin
      sync1 <= next_sync1;
      act <= next_act;
      pwr_sync1 <= next_pwr_sync1;
      pwr_act <= next_pwr_act;
      qual <= next_qual;
      for (int i = 0; i < 4; i++) cnt[i] <= next_cnt[i];
    end
  end
  // A qualified press acts once on its rising edge; holding the pin does nothing more.
  logic [3:0] qual_d;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) qual_d <= '0;
    else qual_d <= qual;
  end
  assign qual_rise = qual & ~qual_d;
  // ----------------------------------------------------------------
  // Power state machine
  // ----------------------------------------------------------------
  mps_pkg::mps_state_type state, next_state, target, next_target;
  logic [7:0] warn_cnt, next_warn_cnt;
  logic wake_any;
  assign wake_any = act[4] | act[5] | (act[8] & smbus_alert_wake_en) | qual_rise[0] | qual_rise[3]
                    | qual_rise[2];
  always_comb begin
    next_state = state;
    next_target = target;
    next_warn_cnt = warn_cnt;
    case (state)
      mps_pkg::MPS_OFF: begin
        if (qual_rise[0] && pwr_act[0]) next_state = mps_pkg::MPS_RUN;
      end
      mps_pkg::MPS_RUN: begin
        if (sw_soft_off || sw_sleep_disk || sw_sleep_ram || qual_rise[3] || qual_rise[2]) begin
          next_target = sw_soft_off ? mps_pkg::MPS_OFF :
                        (sw_sleep_disk ? mps_pkg::MPS_DISK : mps_pkg::MPS_RAM);
          next_warn_cnt = '0;
          next_state = mps_pkg::MPS_WARN;
        end
      end
      mps_pkg::MPS_WARN: begin
        next_warn_cnt = warn_cnt + 1'b1;
        if (warn_cnt == 8'(mps_pkg::SUSPEND_WARN_CYC - 1)) next_state = target;
      end
      mps_pkg::MPS_RAM, mps_pkg::MPS_DISK: begin
        if (wake_any) next_state = mps_pkg::MPS_RUN;
      end
      default: next_state = mps_pkg::MPS_OFF;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= mps_pkg::MPS_OFF;
      target <= mps_pkg::MPS_RAM;
      warn_cnt <= '0;
    end else begin
      state <= next_state;
      target <= next_target;
      warn_cnt <= next_warn_cnt;
    end
  end
  // ----------------------------------------------------------------
  // Carrier reset: a fixed pulse per button, watchdog or software event, so a held button cannot stall the system; bad power holds it low
  // ----------------------------------------------------------------
  logic [7:0] rst_cnt, next_rst_cnt;
  logic rst_cause, bad_power;
  assign bad_power = ~pwr_act[0] | pwr_act[1];
  assign rst_cause = qual_rise[1] | watchdog_timeout | sw_reset_req;
  always_comb begin
    next_rst_cnt = (rst_cnt != '0) ? rst_cnt - 1'b1 : rst_cnt;
    if (rst_cause) next_rst_cnt = 8'(mps_pkg::RESET_HOLD_CYC);
  end
  // ----------------------------------------------------------------
  // Sticky event flags; a new event wins over a clear in the same cycle
  // ----------------------------------------------------------------
  logic [4:0] evt, next_evt, evt_set;
  logic wdt_flag, next_wdt_flag, trip, next_trip;
  assign evt_set = {act[8] & ~smbus_alert_wake_en, qual_rise[3], qual_rise[2], act[6], act[7]};
  always_comb begin
    next_evt = (event_clear ? '0 : evt) | evt_set;
    next_wdt_flag = (event_clear ? 1'b0 : wdt_flag) | watchdog_timeout;
    next_trip = (trip | cpu_thermal_trip) & (state != mps_pkg::MPS_OFF);
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_cnt <= '0;
      evt <= '0;
      wdt_flag <= 1'b0;
      trip <= 1'b0;
      carrier_reset_out_n <= 1'b0;
      suspend_ram_n <= 1'b1;
      suspend_disk_n <= 1'b1;
      soft_off_n <= 1'b0;
      suspend_pending_n <= 1'b1;
    end else begin
      rst_cnt <= next_rst_cnt;
      evt <= next_evt;
      wdt_flag <= next_wdt_flag;
      trip <= next_trip;
      carrier_reset_out_n <= ~(bad_power | (next_rst_cnt != '0));
      suspend_ram_n <= ~(next_state == mps_pkg::MPS_RAM);
      suspend_disk_n <= ~(next_state == mps_pkg::MPS_DISK);
      soft_off_n <= ~(next_state == mps_pkg::MPS_OFF);
      suspend_pending_n <= ~(next_state == mps_pkg::MPS_WARN);
    end
  end
  assign overtemp_event = evt[0];
  assign battery_low_event = evt[1];
  assign lid_event = evt[2];
  assign sleep_button_event = evt[3];
  assign mgmt_interrupt_n = ~evt[4];
  assign watchdog_expired = wdt_flag;
  assign cpu_thermal_shutdown_n = ~trip;
  assign pinout_code_n = mps_pkg::PINOUT_CODE_N;
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_warn_before_sleep: assert property ($rose(~suspend_ram_n) |-> $past(~suspend_pending_n))
    else $error("suspend without warning");
  a_ram_output_state: assert property ((state == mps_pkg::MPS_WARN) && (target == mps_pkg::MPS_RAM)
                                       && (warn_cnt == 8'(mps_pkg::SUSPEND_WARN_CYC - 1))
                                       |=> !suspend_ram_n && suspend_pending_n)
    else $error("ram output mismatch");
  a_disk_off_state: assert property (##1 (suspend_disk_n == (state != mps_pkg::MPS_DISK))
                                     && (soft_off_n == (state != mps_pkg::MPS_OFF)))
    else $error("disk or off output mismatch");
  a_power_bad_reset: assert property (bad_power |=> !carrier_reset_out_n)
    else $error("reset not driven on bad power");
  a_reset_released: assert property ((rst_cnt == 8'h01) && !bad_power && !rst_cause
                                     ##1 !bad_power && !rst_cause |=> carrier_reset_out_n)
    else $error("reset held after pulse");
  a_wdt_sticky: assert property (watchdog_timeout |=> watchdog_expired)
    else $error("watchdog flag not set");
  a_pwr_wakes: assert property (state == mps_pkg::MPS_OFF && qual_rise[0] && pwr_act[0]
                                |=> state == mps_pkg::MPS_RUN)
    else $error("power button ignored");
  a_wake_input: assert property ((state == mps_pkg::MPS_RAM) && act[4] |=> state == mps_pkg::MPS_RUN)
    else $error("wake ignored");
  a_strap_type: assert property (pinout_code_n == 3'h3)
    else $error("strap code wrong");
  a_batt_event: assert property (act[6] |=> battery_low_event)
    else $error("battery event lost");
  c_sleep_ram: cover property (state == mps_pkg::MPS_WARN ##[1:40] state == mps_pkg::MPS_RAM);
  c_wake: cover property (state == mps_pkg::MPS_RAM ##1 state == mps_pkg::MPS_RUN);
  c_reset_pulse: cover property ($fell(carrier_reset_out_n));
endmodule : mps_ctrl

// *** testbench/mps_carrier.sv ***
/*
  Carrier board model: strap decoder and main supply enable.
  Assumes the module straps are static and the supply-on line is combinational.
*/
`timescale 1ns/1ps
module mps_carrier #(
  parameter logic [2:0] ACCEPT_CODE_N = 3'h3
) (
  input wire logic [2:0] pinout_code_n,
  input wire logic suspend_ram_n,
  output logic atx_supply_enable,
  output logic type_fault_led
);
  // Decoding stays combinational so a wrong module never sees a clock edge of main power.
  assign type_fault_led = (pinout_code_n !== ACCEPT_CODE_N);
  // Main power is on except in suspend to RAM or on a strap type fault; an active-low supply-on line is this signal inverted.
  assign atx_supply_enable = suspend_ram_n & ~type_fault_led;
endmodule : mps_carrier

// *** testbench/tb.sv ***
/*
  Self-checking bench of the power-state controller with a carrier model.
  Assumes a shortened qualification count of 8 cycles.
*/
`timescale 1ns/1ps
module tb;
  logic clk, rst_n, power_button_n, reset_button_n, supply_good, main_supply_low, pcie_wake_n, gp_wake_n;
  logic battery_low_n, overtemp_in_n, smbus_alert_n, lid_n, sleep_button, cpu_thermal_trip, watchdog_timeout;
  logic sw_reset_req, sw_sleep_ram, sw_sleep_disk, sw_soft_off, smbus_alert_wake_en, event_clear;
  logic carrier_reset_out_n, suspend_ram_n, suspend_disk_n, soft_off_n, suspend_pending_n, cpu_thermal_shutdown_n;
  logic watchdog_expired, mgmt_interrupt_n, overtemp_event, battery_low_event, lid_event, sleep_button_event;
  logic atx_supply_enable;
  logic [2:0] pinout_code_n;
  logic [15:0] obs;
  logic [31:0] expq[$];
  logic [31:0] ent;
  int num_errors = 0, n_compared = 0, hl;
  event chk;
  localparam logic [15:0] ATX = 16'h8000, PIN = 16'h7000, RST = 16'h0800, RAM = 16'h0400, DSK = 16'h0200;
  localparam logic [15:0] OFF = 16'h0100, PND = 16'h0080, THS = 16'h0040, WDG = 16'h0020, SMI = 16'h0010;
  localparam logic [15:0] OT = 16'h0008, BL = 16'h0004, LID = 16'h0002, SLB = 16'h0001;
  mps_ctrl #(.PULSE_CYC(8)) DUT (.clk, .rst_n, .power_button_n, .reset_button_n, .supply_good, .main_supply_low,
    .pcie_wake_n, .gp_wake_n, .battery_low_n, .overtemp_in_n, .smbus_alert_n, .lid_n, .sleep_button,
    .cpu_thermal_trip, .watchdog_timeout, .sw_reset_req, .sw_sleep_ram, .sw_sleep_disk, .sw_soft_off,
    .smbus_alert_wake_en, .event_clear, .carrier_reset_out_n, .suspend_ram_n, .suspend_disk_n, .soft_off_n,
    .suspend_pending_n, .cpu_thermal_shutdown_n, .watchdog_expired, .mgmt_interrupt_n, .overtemp_event,
    .battery_low_event, .lid_event, .sleep_button_event, .pinout_code_n);
  mps_carrier carrier (.pinout_code_n, .suspend_ram_n, .atx_supply_enable, .type_fault_led());
  assign obs = {atx_supply_enable, pinout_code_n, carrier_reset_out_n, suspend_ram_n, suspend_disk_n, soft_off_n,
    suspend_pending_n, cpu_thermal_shutdown_n, watchdog_expired, mgmt_interrupt_n, overtemp_event,
    battery_low_event, lid_event, sleep_button_event};
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic hold(ref logic s, input logic v, input int n);
    s = v;
    tick(n);
    s = ~v;
  endtask : hold
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value outputs expected %h seen %h", exp, seen);
    end
  endtask : check
  // Waits a bounded time for the pattern, then leaves the note for the watcher.
  task aw(input logic [15:0] m, input logic [15:0] v, input int lim);
    for (int i = 0; i < lim && (obs & m) !== v; i++) tick(1);
    expq.push_back({m, v});
    ->chk;
  endtask : aw
  // Two notes may be left in one time step; drain them all so none is compared late.
  always @(chk) begin
    while (expq.size() > 0) begin
      ent = expq.pop_front();
      check(obs & ent[31:16], ent[15:0]);
    end
  end
  task test_done;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  initial begin
    #3_000_000;
    num_errors++;
    test_done();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, main_supply_low, sleep_button, cpu_thermal_trip, watchdog_timeout, sw_reset_req} = '0;
    {sw_sleep_ram, sw_sleep_disk, sw_soft_off, smbus_alert_wake_en, event_clear} = '0;
    {power_button_n, reset_button_n, supply_good, pcie_wake_n, gp_wake_n} = '1;
    {battery_low_n, overtemp_in_n, smbus_alert_n, lid_n} = '1;
    hl = $urandom(32'hcc06d239);
    tick(3);
    aw(RST | OFF, 16'h0000, 0);
    tick(3);
    rst_n = 1'b1;
    aw(RST | OFF | PIN, RST | 16'h3000, 4);
    supply_good = 1'b0;
    aw(RST, 16'h0000, 5);
    supply_good = 1'b1;
    aw(RST, RST, 40);
    hold(power_button_n, 1'b0, 4);
    tick(20);
    aw(OFF, 16'h0000, 0);
    hl = 12 + ($urandom % 8);
    hold(power_button_n, 1'b0, hl);
    aw(OFF | ATX, OFF | ATX, 30);
    hold(sw_sleep_ram, 1'b1, 1);
    aw(PND | RAM, RAM, 3);
    aw(RAM | PND | ATX, PND, 24);
    hold(pcie_wake_n, 1'b0, 2);
    aw(RAM, RAM, 6);
    hold(sw_sleep_disk, 1'b1, 1);
    aw(DSK | PND, PND, 24);
    hold(gp_wake_n, 1'b0, 2);
    aw(DSK, DSK, 6);
    hold(smbus_alert_n, 1'b0, 3);
    aw(SMI, 16'h0000, 6);
    hold(lid_n, 1'b0, 12);
    aw(LID | RAM, LID, 40);
    smbus_alert_wake_en = 1'b1;
    hold(smbus_alert_n, 1'b0, 3);
    aw(RAM, RAM, 6);
    hold(sw_sleep_ram, 1'b1, 1);
    aw(RAM, 16'h0000, 30);
    hold(sleep_button, 1'b1, 12);
    aw(SLB | RAM, SLB | RAM, 30);
    battery_low_n = 1'b0;
    hold(overtemp_in_n, 1'b0, 4);
    battery_low_n = 1'b1;
    aw(BL | OT, BL | OT, 6);
    // The released pins are still high in the two sync flops, and a set beats a clear.
    tick(3);
    hold(event_clear, 1'b1, 1);
    aw(BL | OT | LID | SLB, 16'h0000, 3);
    hold(watchdog_timeout, 1'b1, 1);
    aw(WDG | RST, WDG, 4);
    aw(RST, RST, 40);
    hold(sw_reset_req, 1'b1, 1);
    aw(RST, 16'h0000, 3);
    aw(RST, RST, 40);
    reset_button_n = 1'b0;
    aw(RST, 16'h0000, 20);
    aw(RST, RST, 40);
    reset_button_n = 1'b1;
    hold(main_supply_low, 1'b1, 2);
    aw(RST, 16'h0000, 3);
    aw(RST, RST, 40);
    cpu_thermal_trip = 1'b1;
    aw(THS, 16'h0000, 3);
    hold(sw_soft_off, 1'b1, 1);
    aw(OFF | THS, THS, 30);
    tick(2);
    test_done();
  end
endmodule : tb
